// file: inc/spd_defines.vh
// Op codes, register addresses and field sizes of the pointer command decoder
`ifndef SPD_DEFINES_VH
`define SPD_DEFINES_VH

// Pointer selection op codes; low two bits pick the pointer
`define SPD_OP_SEL_A 8'hd8
`define SPD_OP_SEL_B 8'hd9
`define SPD_OP_SEL_C 8'hda
`define SPD_OP_SEL_D 8'hdb

// Pointer arithmetic without data transfer
`define SPD_OP_ADD1 8'hd0
`define SPD_OP_ADD2 8'hd2
`define SPD_OP_ADD4 8'hd4

// Plain pointer read and write
`define SPD_OP_RD 8'h40
`define SPD_OP_WR 8'hc0
`define SPD_OP_INC_WR 8'hc8

// Special purpose commands
`define SPD_OP_RD_CCW 8'h48
`define SPD_OP_RD_IND0 8'h68
`define SPD_OP_RD_IND1 8'h70
`define SPD_OP_RD_IND2 8'h78
`define SPD_OP_WR_IND0 8'he8
`define SPD_OP_WR_IND1 8'hf0
`define SPD_OP_WR_IND2 8'hf8
`define SPD_OP_RD_ADD4 8'h60
`define SPD_OP_RD_LOG 8'h58

// Register locations served inside the block, and the pointer reset value
`define SPD_REG_CCW 16'h0003
`define SPD_REG_PTR_A 16'h000b
`define SPD_REG_PTR_B 16'h000c
`define SPD_REG_PTR_C 16'h000d
`define SPD_REG_PTR_D 16'h000e
`define SPD_PTR_RESET 16'h0000

// Location where multi-word reads stop advancing
`define SPD_NOINC_ADDR 16'h0403

// Serial framing: last bit index of op code and of data word
`define SPD_OPC_LAST 4'h7
`define SPD_WORD_LAST 4'hf

// Write buffer entry: address in the upper half, data in the lower
`define SPD_BUF_W 32

`endif

// file: design/spd_buf.v
// Two-entry valid/ready buffer for host write words
`timescale 1ns/1ps
`default_nettype none
`include "spd_defines.vh"

module spd_buf #(
   parameter W = `SPD_BUF_W
) (
   input wire clk_i,
   input wire rstn_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);

   reg [W-1:0] ent_q [0:1];
   reg wp_q;
   reg rp_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;

   assign in_ready_o = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o = ent_q[rp_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ent_q[0] <= {W{1'b0}};
         ent_q[1] <= {W{1'b0}};
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            ent_q[wp_q] <= in_data_i;
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         case ({push, pop})
            2'b10: cnt_q <= cnt_q + 2'h1;
            2'b01: cnt_q <= cnt_q - 2'h1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

endmodule // spd_buf

`default_nettype wire

// file: design/spd_core.v
// SPI slave that decodes memory address pointer commands
// Function
// - D8 to DB select the enabled pointer
// - D0, D2, D4 add 1, 2, 4
// - Pointer reaches RAM and register locations
// - 40 returns word at pointer
// - C0 stores host word at pointer
// - C8 increments pointer then stores word
// - 48 loads pointer from register 3, reads
// - 68/70/78 add, follow link, then read
// - E8/F0/F8 add, follow link, then write
// - 60 reads then adds 4
// - 58 loads log address, reads log word
// - 58 decrements pointer after the read
// - Multi-word 40/48/68/70/78 read advances, except at stop address
`timescale 1ns/1ps
`default_nettype none
`include "spd_defines.vh"

module spd_core (
   input wire clk_i,
   input wire rstn_i,
   input wire spi_sck_i,
   input wire spi_cs_n_i,
   input wire spi_mosi_i,
   output wire spi_miso_o,
   output wire spi_miso_oe_n_o,
   output wire [15:0] mem_addr_o,
   output wire mem_rd_o,
   output wire mem_wr_o,
   output wire [15:0] mem_wdata_o,
   input wire [15:0] mem_rdata_i,
   input wire mem_wr_ready_i,
   input wire [15:0] ccw_addr_i,
   input wire [15:0] ilog_addr_i,
   output wire [1:0] ptr_sel_o,
   output wire [15:0] cur_ptr_o,
   output wire wr_overrun_o
);

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_IND = 2'h1;
   localparam [1:0] S_XFER = 2'h2;
   localparam [1:0] M_NONE = 2'h0;
   localparam [1:0] M_RD = 2'h1;
   localparam [1:0] M_WR = 2'h2;

   function is_ptr;
      input [15:0] a;
      begin
         is_ptr = (a >= `SPD_REG_PTR_A) && (a <= `SPD_REG_PTR_D);
      end
   endfunction

   function [1:0] pidx;
      input [15:0] a;
      reg [15:0] d;
      begin
         d = a - `SPD_REG_PTR_A;
         pidx = d[1:0];
      end
   endfunction

   // Auto-advance that holds still at the stop address
   function [15:0] step;
      input [15:0] a;
      begin
         if (a == `SPD_NOINC_ADDR) begin
            step = a;
         end else begin
            step = a + 16'h0001;
         end
      end
   endfunction

   // Pin synchronisers; the first stage feeds only the second
   reg sck_s1_q;
   reg sck_s2_q;
   reg sck_s3_q;
   reg cs_s1_q;
   reg cs_s2_q;
   reg mosi_s1_q;
   reg mosi_s2_q;

   reg [15:0] rx_q;
   reg [3:0] cnt_q;
   reg opd_q;
   reg [15:0] tx_q;
   reg [15:0] nxt_q;

   reg [15:0] ptr_q [0:3];
   reg [1:0] sel_q;
   reg [1:0] state_q;
   reg [1:0] mode_q;
   reg [7:0] opc_q;
   reg first_q;
   reg pend_q;
   reg [15:0] pend_addr_q;
   reg ovr_q;

   reg rd_q;
   reg [15:0] rd_addr_q;
   reg rdv_q;
   reg loc_hit_q;
   reg [15:0] loc_q;

   integer i;

   wire cs_act = ~cs_s2_q;
   wire sck_rise = sck_s2_q & ~sck_s3_q;
   wire sck_fall = ~sck_s2_q & sck_s3_q;
   wire [7:0] op_byte = {rx_q[6:0], mosi_s2_q};
   wire [15:0] rx_word = {rx_q[14:0], mosi_s2_q};
   wire op_ev = sck_rise & cs_act & ~opd_q & (cnt_q == `SPD_OPC_LAST);
   wire wd_ev = sck_rise & cs_act & opd_q & (cnt_q == `SPD_WORD_LAST);
   wire [15:0] cur = ptr_q[sel_q];
   wire [15:0] ind_k = {14'h0000, op_byte[4:3]} - 16'h0001;
   wire [15:0] ind_addr = cur + ind_k;
   wire [15:0] rdata = loc_hit_q ? loc_q : mem_rdata_i;
   wire rd_loc = is_ptr(rd_addr_q) | (rd_addr_q == `SPD_REG_CCW);
   wire [15:0] loc_val = is_ptr(rd_addr_q) ? ptr_q[pidx(rd_addr_q)] : ccw_addr_i;
   wire [15:0] rd_start = (op_byte == `SPD_OP_RD_CCW) ? ccw_addr_i :
      ((op_byte == `SPD_OP_RD_LOG) ? ilog_addr_i : cur);

   // Write path through the buffer; memory reads have the shared port first
   wire [15:0] waddr = first_q ? cur : step(cur);
   wire bi_valid = wd_ev & (state_q == S_XFER) & (mode_q == M_WR);
   wire bi_ready;
   wire bo_valid;
   wire bo_ready;
   wire [31:0] bo_data;
   wire [15:0] bo_addr = bo_data[31:16];
   wire bo_local = is_ptr(bo_addr) | (bo_addr == `SPD_REG_CCW);

   assign bo_ready = ~mem_rd_o & (bo_local | mem_wr_ready_i);
   assign mem_rd_o = rd_q & ~rd_loc;
   assign mem_wr_o = bo_valid & ~mem_rd_o & ~bo_local;
   assign mem_addr_o = mem_rd_o ? rd_addr_q : bo_addr;
   assign mem_wdata_o = bo_data[15:0];
   assign spi_miso_o = tx_q[15];
   assign spi_miso_oe_n_o = ~(cs_act & (mode_q == M_RD));
   assign ptr_sel_o = sel_q;
   assign cur_ptr_o = cur;
   assign wr_overrun_o = ovr_q;

   spd_buf #(
      .W(`SPD_BUF_W)
   ) u_wbuf (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(bi_valid),
      .in_ready_o(bi_ready),
      .in_data_i({waddr, rx_word}),
      .out_valid_o(bo_valid),
      .out_ready_i(bo_ready),
      .out_data_o(bo_data)
   );

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         mosi_s1_q <= 1'b0;
         mosi_s2_q <= 1'b0;
      end else begin
         sck_s1_q <= spi_sck_i;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         cs_s1_q <= spi_cs_n_i;
         cs_s2_q <= cs_s1_q;
         mosi_s1_q <= spi_mosi_i;
         mosi_s2_q <= mosi_s1_q;
      end
   end

   // Bit counter; only the first byte of a frame is an op code
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_q <= 16'h0000;
         cnt_q <= 4'h0;
         opd_q <= 1'b0;
      end else if (!cs_act) begin
         cnt_q <= 4'h0;
         opd_q <= 1'b0;
      end else if (sck_rise) begin
         rx_q <= rx_word;
         if (op_ev) begin
            cnt_q <= 4'h0;
            opd_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   // Mode 0: a new word is loaded on the fall that follows its predecessor
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_q <= 16'h0000;
      end else if (!cs_act) begin
         tx_q <= 16'h0000;
      end else if (sck_fall & opd_q) begin
         if (cnt_q == 4'h0) begin
            tx_q <= nxt_q;
         end else begin
            tx_q <= {tx_q[14:0], 1'b0};
         end
      end
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            ptr_q[i] <= `SPD_PTR_RESET;
         end
         sel_q <= 2'h0;
         state_q <= S_IDLE;
         mode_q <= M_NONE;
         opc_q <= 8'h00;
         first_q <= 1'b0;
         pend_q <= 1'b0;
         pend_addr_q <= 16'h0000;
         ovr_q <= 1'b0;
         rd_q <= 1'b0;
         rd_addr_q <= 16'h0000;
         rdv_q <= 1'b0;
         loc_hit_q <= 1'b0;
         loc_q <= 16'h0000;
         nxt_q <= 16'h0000;
      end else begin
         rd_q <= 1'b0;
         rdv_q <= rd_q;
         loc_hit_q <= rd_q & rd_loc;
         loc_q <= loc_val;
         if (bo_valid & bo_ready & is_ptr(bo_addr)) begin
            ptr_q[pidx(bo_addr)] <= bo_data[15:0];
         end
         if (bi_valid & ~bi_ready) begin
            ovr_q <= 1'b1;
         end
         if (!cs_act) begin
            state_q <= S_IDLE;
            mode_q <= M_NONE;
            pend_q <= 1'b0;
         end else begin
            case (state_q)
               S_IDLE: begin
                  if (op_ev) begin
                     opc_q <= op_byte;
                     first_q <= 1'b1;
                     ovr_q <= 1'b0;
                     case (op_byte)
                        `SPD_OP_SEL_A, `SPD_OP_SEL_B, `SPD_OP_SEL_C, `SPD_OP_SEL_D: begin
                           sel_q <= op_byte[1:0];
                        end
                        `SPD_OP_ADD1: ptr_q[sel_q] <= cur + 16'h0001;
                        `SPD_OP_ADD2: ptr_q[sel_q] <= cur + 16'h0002;
                        `SPD_OP_ADD4: ptr_q[sel_q] <= cur + 16'h0004;
                        `SPD_OP_RD, `SPD_OP_RD_ADD4, `SPD_OP_RD_CCW, `SPD_OP_RD_LOG: begin
                           ptr_q[sel_q] <= rd_start;
                           rd_q <= 1'b1;
                           rd_addr_q <= rd_start;
                           mode_q <= M_RD;
                           state_q <= S_XFER;
                        end
                        `SPD_OP_RD_IND0, `SPD_OP_RD_IND1, `SPD_OP_RD_IND2,
                        `SPD_OP_WR_IND0, `SPD_OP_WR_IND1, `SPD_OP_WR_IND2: begin
                           ptr_q[sel_q] <= ind_addr;
                           rd_q <= 1'b1;
                           rd_addr_q <= ind_addr;
                           mode_q <= op_byte[7] ? M_WR : M_RD;
                           state_q <= S_IND;
                        end
                        `SPD_OP_WR: begin
                           mode_q <= M_WR;
                           state_q <= S_XFER;
                        end
                        `SPD_OP_INC_WR: begin
                           ptr_q[sel_q] <= cur + 16'h0001;
                           mode_q <= M_WR;
                           state_q <= S_XFER;
                        end
                        default: mode_q <= M_NONE; // Other op codes belong to other decoders
                     endcase
                  end
               end
               S_IND: begin
                  if (rdv_q) begin
                     ptr_q[sel_q] <= rdata;
                     rd_q <= (mode_q == M_RD);
                     rd_addr_q <= rdata;
                     state_q <= S_XFER;
                  end
               end
               S_XFER: begin
                  if (rdv_q & (mode_q == M_RD)) begin
                     nxt_q <= rdata;
                  end
                  // Pointer moves only once the next word is really clocked
                  if (pend_q & sck_rise & (cnt_q == 4'h0)) begin
                     ptr_q[sel_q] <= pend_addr_q;
                     pend_q <= 1'b0;
                  end
                  if (wd_ev & (mode_q == M_RD)) begin
                     rd_q <= 1'b1;
                     if (opc_q == `SPD_OP_RD_ADD4) begin
                        ptr_q[sel_q] <= cur + 16'h0004;
                        rd_addr_q <= cur + 16'h0004;
                     end else if (opc_q == `SPD_OP_RD_LOG) begin
                        ptr_q[sel_q] <= cur - 16'h0001;
                        rd_addr_q <= cur - 16'h0001;
                     end else begin
                        rd_addr_q <= step(cur);
                        pend_addr_q <= step(cur);
                        pend_q <= 1'b1;
                     end
                  end
                  if (wd_ev & (mode_q == M_WR)) begin
                     first_q <= 1'b0;
                     if (!first_q) begin
                        ptr_q[sel_q] <= step(cur);
                     end
                  end
               end
               default: state_q <= S_IDLE;
            endcase
         end
      end
   end

endmodule // spd_core

`default_nettype wire

// file: bench/spd_core_assertions.sv
// Port-level checks for the pointer command decoder
`timescale 1ns/1ps
`default_nettype none
module spd_core_chk (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   input wire logic spi_miso_o,
   input wire logic spi_miso_oe_n_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic mem_rd_o,
   input wire logic mem_wr_o,
   input wire logic [15:0] mem_wdata_o,
   input wire logic [15:0] mem_rdata_i,
   input wire logic mem_wr_ready_i,
   input wire logic [15:0] ccw_addr_i,
   input wire logic [15:0] ilog_addr_i,
   input wire logic [1:0] ptr_sel_o,
   input wire logic [15:0] cur_ptr_o,
   input wire logic wr_overrun_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Allows for the select synchroniser before the driver lets go
   property p_oe_idle;
      spi_cs_n_i [*5] |-> spi_miso_oe_n_o;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");
   property p_rd_wins;
      mem_rd_o |-> !mem_wr_o;
   endproperty
   a_rd_wins: assert property (p_rd_wins) else $error("write issued in a read cycle");
   property p_wr_hold;
      mem_wr_o && !mem_wr_ready_i |=>
         mem_rd_o || (mem_wr_o && $stable(mem_wdata_o) && $stable(mem_addr_o));
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("stalled write not held");
   property p_local;
      mem_rd_o || mem_wr_o |-> !(mem_addr_o inside {16'h0003, [16'h000b:16'h000e]});
   endproperty
   a_local: assert property (p_local) else $error("register address sent to memory");
   property p_sel_idle;
      spi_cs_n_i [*6] |=> $stable(ptr_sel_o);
   endproperty
   a_sel_idle: assert property (p_sel_idle) else $error("pointer select moved while idle");
   property p_rd_idle;
      spi_cs_n_i [*6] |-> !mem_rd_o;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("memory read outside a frame");
   property p_ovr_sticky;
      wr_overrun_o && spi_cs_n_i |=> wr_overrun_o;
   endproperty
   a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun flag lost");
   property p_miso_hold;
      spi_sck_i [*5] |-> $stable(spi_miso_o);
   endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved while clock high");
   c_stall: cover property (mem_wr_o && !mem_wr_ready_i [*4]);
   c_ovr: cover property ($rose(wr_overrun_o));
   c_hold: cover property (mem_rd_o && mem_addr_o == 16'h0403);
endmodule // spd_core_chk
bind spd_core spd_core_chk u_chk (
   .clk_i(clk_i),
   .rstn_i(rstn_i),
   .spi_sck_i(spi_sck_i),
   .spi_cs_n_i(spi_cs_n_i),
   .spi_mosi_i(spi_mosi_i),
   .spi_miso_o(spi_miso_o),
   .spi_miso_oe_n_o(spi_miso_oe_n_o),
   .mem_addr_o(mem_addr_o),
   .mem_rd_o(mem_rd_o),
   .mem_wr_o(mem_wr_o),
   .mem_wdata_o(mem_wdata_o),
   .mem_rdata_i(mem_rdata_i),
   .mem_wr_ready_i(mem_wr_ready_i),
   .ccw_addr_i(ccw_addr_i),
   .ilog_addr_i(ilog_addr_i),
   .ptr_sel_o(ptr_sel_o),
   .cur_ptr_o(cur_ptr_o),
   .wr_overrun_o(wr_overrun_o)
);
`default_nettype wire

// file: bench/spd_host_model.sv
// Serial host model: mode 0 master, one command per select frame
`timescale 1ns/1ps
`default_nettype none
module spd_host_model (
   output logic sck_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic oe_n_i
);
   logic [15:0] wd [0:3];
   logic [15:0] rd [0:3];
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Clock runs only inside frames; an undriven miso reads as unknown
   task automatic bit_xfer(input logic b, output logic r);
      mosi_o = b;
      #80 sck_o = 1'b1;
      r = oe_n_i ? 1'bx : miso_i;
      #80 sck_o = 1'b0;
   endtask
   task automatic frame(input logic [7:0] op, input int nw);
      logic r;
      cs_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) bit_xfer(op[i], r);
      for (int j = 0; j < nw; j++) begin
         for (int i = 15; i >= 0; i--) begin
            bit_xfer(wd[j][i], r);
            rd[j][i] = r;
         end
      end
      #80 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #200;
   endtask
endmodule // spd_host_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the pointer command decoder
`timescale 1ns/1ps
`default_nettype none
`include "spd_defines.vh"
module tb;
   logic clk_i;
   logic rstn_i;
   logic mem_wr_ready_i;
   logic [15:0] mem_rdata_i = 16'h0000;
   logic [15:0] ccw_addr_i;
   logic [15:0] ilog_addr_i;
   wire spi_sck_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_n_o;
   wire mem_rd_o, mem_wr_o, wr_overrun_o;
   wire [15:0] mem_addr_o, mem_wdata_o, cur_ptr_o;
   wire [1:0] ptr_sel_o;
   logic [15:0] ram [0:4095];
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   int k;
   spd_core DUT (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .spi_sck_i(spi_sck_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_mosi_i(spi_mosi_i),
      .spi_miso_o(spi_miso_o),
      .spi_miso_oe_n_o(spi_miso_oe_n_o),
      .mem_addr_o(mem_addr_o),
      .mem_rd_o(mem_rd_o),
      .mem_wr_o(mem_wr_o),
      .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i),
      .mem_wr_ready_i(mem_wr_ready_i),
      .ccw_addr_i(ccw_addr_i),
      .ilog_addr_i(ilog_addr_i),
      .ptr_sel_o(ptr_sel_o),
      .cur_ptr_o(cur_ptr_o),
      .wr_overrun_o(wr_overrun_o)
   );
   spd_host_model host (.sck_o(spi_sck_i), .cs_n_o(spi_cs_n_i), .mosi_o(spi_mosi_i),
      .miso_i(spi_miso_o), .oe_n_i(spi_miso_oe_n_o));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Memory: data valid one cycle after the read strobe, scrambled otherwise
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      mem_rdata_i <= mem_rd_o ? ram[mem_addr_o[11:0]] : ~mem_rdata_i;
      if (mem_wr_o && mem_wr_ready_i) begin
         ram[mem_addr_o[11:0]] <= mem_wdata_o;
      end
   end
   always @(posedge clk_i) begin
      if (cyc == 30000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   function automatic logic [15:0] pat(input int a);
      return 16'(a * 7) ^ 16'h3c5a;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [7:0] code, input int nw);
      @(negedge clk_i);
      host.frame(code, nw);
   endtask
   // Pointer D rests on the pointer A register, so one write reloads A
   task automatic seta(input logic [15:0] v);
      op(`SPD_OP_SEL_D, 0);
      host.wd[0] = v;
      op(`SPD_OP_WR, 1);
      op(`SPD_OP_SEL_A, 0);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      rstn_i = 1'b0;
      mem_wr_ready_i = 1'b1;
      ccw_addr_i = 16'h0600;
      ilog_addr_i = 16'h0a05;
      for (k = 0; k < 4096; k++) ram[k] = pat(k);
      for (k = 0; k < 3; k++) ram[12'h700 + k] = 16'(16'h0800 + 16 * k);
      repeat (5) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge clk_i);
      op(`SPD_OP_SEL_D, 0);
      op(`SPD_OP_ADD4, 0);
      op(`SPD_OP_ADD4, 0);
      op(`SPD_OP_ADD2, 0);
      op(`SPD_OP_ADD1, 0);
      chk(cur_ptr_o, `SPD_REG_PTR_A);
      chk({14'h0, ptr_sel_o}, 16'h0003);
      seta(16'h0100);
      chk(cur_ptr_o, 16'h0100);
      op(`SPD_OP_SEL_D, 0);
      op(`SPD_OP_RD, 1);
      chk(host.rd[0], 16'h0100);
      chk(cur_ptr_o, `SPD_REG_PTR_A);
      op(`SPD_OP_SEL_A, 0);
      op(`SPD_OP_RD, 4);
      for (k = 0; k < 4; k++) chk(host.rd[k], pat(16'h0100 + k));
      chk(cur_ptr_o, 16'h0103);
      seta(16'h0401);
      op(`SPD_OP_RD, 4);
      for (k = 0; k < 4; k++) chk(host.rd[k], pat(k < 3 ? 16'h0401 + k : 16'h0403));
      op(`SPD_OP_RD_CCW, 1);
      chk(host.rd[0], pat(16'h0600));
      chk(cur_ptr_o, 16'h0600);
      for (k = 0; k < 3; k++) begin
         seta(16'h0700);
         op(`SPD_OP_RD_IND0 + 8'(8 * k), 1);
         chk(host.rd[0], pat(16'h0800 + 16 * k));
         chk(cur_ptr_o, 16'(16'h0800 + 16 * k));
      end
      for (k = 0; k < 3; k++) begin
         seta(16'h0700);
         host.wd[0] = 16'hbe00 + 16'(k);
         op(`SPD_OP_WR_IND0 + 8'(8 * k), 1);
         chk(ram[12'h800 + 12'(16 * k)], 16'hbe00 + 16'(k));
      end
      seta(16'h0500);
      host.wd[0] = 16'h1234;
      op(`SPD_OP_WR, 1);
      host.wd[0] = 16'h5678;
      op(`SPD_OP_INC_WR, 1);
      chk(ram[12'h500], 16'h1234);
      chk(ram[12'h501], 16'h5678);
      chk(cur_ptr_o, 16'h0501);
      seta(16'h0900);
      op(`SPD_OP_RD_ADD4, 2);
      chk(host.rd[0], pat(16'h0900));
      chk(host.rd[1], pat(16'h0904));
      chk(cur_ptr_o, 16'h0908);
      op(`SPD_OP_RD_LOG, 2);
      chk(host.rd[0], pat(16'h0a05));
      chk(host.rd[1], pat(16'h0a04));
      chk(cur_ptr_o, 16'h0a03);
      seta(16'h0b00);
      mem_wr_ready_i = 1'b0;
      for (k = 0; k < 3; k++) host.wd[k] = 16'hc001 + 16'(k);
      op(`SPD_OP_WR, 3);
      chk({15'h0, wr_overrun_o}, 16'h0001);
      mem_wr_ready_i = 1'b1;
      repeat (10) @(negedge clk_i);
      chk(ram[12'hb00], 16'hc001);
      chk(ram[12'hb01], 16'hc002);
      op(`SPD_OP_ADD1, 0);
      chk({15'h0, wr_overrun_o}, 16'h0000);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
